// ---- logic/cst_sequencer.sv ----
// Conversion sequencer with acquisition timing, averaging and chain forwarding
`timescale 1ns/1ps
// What this block does, and what the host must do
// RULE_01: Acquisition length from two-bit select field
// RULE_02: Shortest acquisition time after reset
// RULE_03: Repeat each channel 1/2/4/8 times, store average
// RULE_04: Averaging defaults to single conversion
// RULE_05: All repeats finish before next channel
// RULE_06: Averaged result uses ordinary result path
// RULE_07: Host waits 90 us after averaging change
// RULE_08: Second write's chip-select edge starts conversion
// RULE_09: Start forwarded upward, one delay per hop
// RULE_10: Chain serves up to eight devices
// RULE_11: Conversions equal channels times averages
// RULE_12: Sequence time follows acquisition/conversion formula
// RULE_13: Cells first, then auxiliary channels
// RULE_14: Return to top cell before next start
// RULE_15: Host spaces starts one window apart
// RULE_16: Two-bit field picks converted channel set
// RULE_17: Cells descend, auxiliaries ascend
// RULE_18: Host waits 5 us before readback
// RULE_19: Averaging code 00/01/10/11 is 1/2/4/8
// RULE_20: Average is sum shifted by log2 count
// RULE_21: End-of-conversion pulse advances the sequencer
module cst_sequencer
  import cst_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration write
  input wire logic cfg_write,
  input wire logic [1:0] acquisition_time_select,
  input wire logic [1:0] averaging_count_select,
  input wire logic [1:0] channel_set_select,
  // Start requests
  input wire logic convert_start_pin,
  input wire logic cs_start,
  input wire logic chain_start_in,
  // Converter sample from the analog core
  input wire logic [11:0] adc_sample,
  // Chain and status outputs
  output logic chain_start_out,
  output logic busy,
  output logic eoc_pulse,
  output logic [3:0] mux_channel,
  output logic acq_phase,
  output logic result_valid,
  output logic [3:0] result_channel,
  output logic [11:0] result_data
);

  // Control fields
  logic [1:0] acq_sel_reg;
  logic [1:0] avg_sel_reg;
  logic [1:0] chset_sel_reg;
  // Sequencer state and counters
  cst_state_t state_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [3:0] rep_reg;
  logic [14:0] sum_reg;
  logic [3:0] ch_reg;
  // Chain forwarding delay line
  logic [CHAIN_DELAY_CYC-1:0] chain_dly_reg;
  // Start detection and derived acquisition, averaging and channel signals
  logic start_req;
  logic [TMR_W-1:0] acq_cyc;
  logic [3:0] avg_count;
  logic last_rep;
  logic last_ch;
  logic [3:0] next_ch;
  logic [14:0] sum_next;
  // Helper: cycles spent in the current acquisition
  logic [TMR_W-1:0] acq_len_reg;

  // Start from pin, chip-select edge or neighbour below
  assign start_req = convert_start_pin | cs_start | chain_start_in; // RULE_08 RULE_09

  // Acquisition cycles: (code + 1) steps of 400 ns
  assign acq_cyc = TMR_W'(ACQ_STEP_CYC * (32'(acq_sel_reg) + 1)); // RULE_01

  // Repeat count from averaging code
  assign avg_count = 4'h1 << avg_sel_reg; // RULE_19
  assign last_rep = (rep_reg == avg_count - 4'h1); // RULE_05

  // Last channel of the selected set
  always_comb begin
    last_ch = 1'b0;
    next_ch = ch_reg + 4'h1;
    case (chset_sel_reg) // RULE_16
      CHSET_ALL: begin
        last_ch = (ch_reg == CH_LAST_AUX);
      end
      CHSET_ODD_AUX: begin
        last_ch = (ch_reg == CH_LAST_AUX - 4'h1);
        // Aux 1, 3, 5 only
        if (ch_reg >= CH_FIRST_AUX) begin
          next_ch = ch_reg + 4'h2;
        end
      end
      CHSET_CELLS: begin
        last_ch = (ch_reg == CH_LAST_CELL);
      end
      default: begin
        last_ch = 1'b1;
      end
    endcase
  end

  // Running sum including this sample
  assign sum_next = sum_reg + {3'h0, adc_sample}; // RULE_03

  // Configuration capture; ignored while a sequence runs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acq_sel_reg <= ACQ_SEL_RST; // RULE_02
      avg_sel_reg <= AVG_SEL_RST; // RULE_04
      chset_sel_reg <= CHSET_SEL_RST;
    end else if (cfg_write && state_reg == CST_IDLE) begin
      acq_sel_reg <= acquisition_time_select;
      avg_sel_reg <= averaging_count_select;
      chset_sel_reg <= channel_set_select;
    end
  end

  // Main sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= CST_IDLE;
      tmr_reg <= '0;
      rep_reg <= 4'h0;
      sum_reg <= 15'h0000;
      ch_reg <= CH_TOP_CELL;
    end else begin
      case (state_reg)
        // Top cell acquired and waiting for start
        CST_IDLE: begin
          if (start_req) begin // RULE_14
            state_reg <= CST_ACQ;
            tmr_reg <= '0;
            rep_reg <= 4'h0;
            sum_reg <= 15'h0000;
            ch_reg <= (chset_sel_reg == CHSET_SELFTEST) ? CH_SELFTEST : CH_TOP_CELL;
          end
        end
        // Track phase
        CST_ACQ: begin
          if (tmr_reg == acq_cyc - 1'b1) begin // RULE_01 RULE_12
            state_reg <= CST_CONV;
            tmr_reg <= '0;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        // Conversion phase
        CST_CONV: begin
          if (tmr_reg == TMR_W'(CONV_CYC - 1)) begin // RULE_12
            tmr_reg <= '0;
            if (!last_rep) begin // RULE_05
              rep_reg <= rep_reg + 4'h1;
              sum_reg <= sum_next;
              state_reg <= CST_ACQ;
            end else if (!last_ch) begin // RULE_13 RULE_17
              rep_reg <= 4'h0;
              sum_reg <= 15'h0000;
              ch_reg <= next_ch;
              state_reg <= CST_ACQ;
            end else begin
              rep_reg <= 4'h0;
              sum_reg <= 15'h0000;
              ch_reg <= CH_TOP_CELL; // RULE_14
              state_reg <= CST_RETURN; // RULE_11
            end
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        // Handing back to the cell multiplexer
        CST_RETURN: begin
          if (tmr_reg == TMR_W'(RETURN_CYC - 1)) begin // RULE_14
            state_reg <= CST_IDLE;
            tmr_reg <= '0;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        default: begin
          state_reg <= CST_IDLE;
        end
      endcase
    end
  end

  // End-of-conversion pulse and averaged result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      eoc_pulse <= 1'b0;
      result_valid <= 1'b0;
      result_channel <= CH_TOP_CELL;
      result_data <= 12'h000;
    end else begin
      eoc_pulse <= (state_reg == CST_CONV) && (tmr_reg == TMR_W'(CONV_CYC - 1)); // RULE_21
      result_valid <= (state_reg == CST_CONV) && (tmr_reg == TMR_W'(CONV_CYC - 1)) && last_rep; // RULE_06
      if ((state_reg == CST_CONV) && (tmr_reg == TMR_W'(CONV_CYC - 1)) && last_rep) begin
        result_channel <= ch_reg;
        result_data <= 12'(sum_next >> avg_sel_reg); // RULE_20
      end
    end
  end

  // Chain forwarding, one delay per hop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chain_dly_reg <= '0;
      chain_start_out <= 1'b0;
    end else begin
      chain_dly_reg <= {chain_dly_reg[CHAIN_DELAY_CYC-2:0], start_req && state_reg == CST_IDLE}; // RULE_09 RULE_10
      chain_start_out <= chain_dly_reg[CHAIN_DELAY_CYC-1];
    end
  end

  // Status outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      mux_channel <= CH_TOP_CELL;
      acq_phase <= 1'b1;
    end else begin
      busy <= (state_reg != CST_IDLE) || start_req;
      mux_channel <= ch_reg;
      acq_phase <= (state_reg != CST_CONV);
    end
  end

  // Counts acquisition cycles so their length can be checked without long repeats
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acq_len_reg <= '0;
    end else if (state_reg == CST_ACQ) begin
      acq_len_reg <= acq_len_reg + 1'b1;
    end else begin
      acq_len_reg <= '0;
    end
  end

  // Assertions
  AST_ACQ_LEN: assert property (@(posedge clock) disable iff (rst) // RULE_01
    (state_reg == CST_CONV && $past(state_reg) == CST_ACQ) |->
      acq_len_reg == TMR_W'(ACQ_STEP_CYC * (32'(acq_sel_reg) + 1)))
    else $error("acquisition length wrong");
  AST_RST_ACQ: assert property (@(posedge clock) // RULE_02
    $fell(rst) |-> acq_sel_reg == 2'h0)
    else $error("acquisition select not shortest after reset");
  AST_RST_AVG: assert property (@(posedge clock) // RULE_04
    $fell(rst) |-> avg_count == 4'h1)
    else $error("averaging not single after reset");
  AST_REPEAT: assert property (@(posedge clock) disable iff (rst) // RULE_05
    (state_reg == CST_CONV && tmr_reg == TMR_W'(CONV_CYC - 1) && !last_rep) |=> $stable(ch_reg))
    else $error("channel moved before repeats done");
  AST_EOC: assert property (@(posedge clock) disable iff (rst) // RULE_21
    result_valid |-> eoc_pulse)
    else $error("result without end of conversion");
  AST_AVG: assert property (@(posedge clock) disable iff (rst) // RULE_20
    (state_reg == CST_CONV && tmr_reg == TMR_W'(CONV_CYC - 1) && last_rep) |=> result_data == 12'($past(sum_next) >> avg_sel_reg))
    else $error("average wrong");
  AST_ORDER: assert property (@(posedge clock) disable iff (rst) // RULE_17
    (state_reg == CST_ACQ && $changed(ch_reg)) |-> ch_reg > $past(ch_reg))
    else $error("channel order wrong");
  AST_TOP: assert property (@(posedge clock) disable iff (rst) // RULE_14
    state_reg == CST_RETURN |-> ch_reg == CH_TOP_CELL)
    else $error("not back at top cell");
  AST_CHAIN: assert property (@(posedge clock) disable iff (rst) // RULE_09
    (start_req && state_reg == CST_IDLE) |-> ##3 chain_start_out)
    else $error("start not forwarded");
  // Cover scenarios
  CV_AVG8: cover property (@(posedge clock) disable iff (rst) result_valid && avg_sel_reg == 2'h3);
  CV_AUX: cover property (@(posedge clock) disable iff (rst) result_valid && result_channel == CH_LAST_AUX);
  CV_ODD: cover property (@(posedge clock) disable iff (rst) result_valid && chset_sel_reg == CHSET_ODD_AUX);
  CV_DONE: cover property (@(posedge clock) disable iff (rst) state_reg == CST_RETURN ##1 state_reg == CST_RETURN);

endmodule

// ---- logic/cst_pkg.sv ----
// Constants and types for the conversion sequencer
package cst_pkg;
  // Clock period in picoseconds (50 MHz)
  localparam int CLK_PERIOD_PS = 20000;
  // Acquisition time steps in ns
  localparam int ACQ_STEP_NS = 400;
  // Conversion time in ns
  localparam int CONV_TIME_NS = 695;
  // Settle time after an averaging change, in us
  localparam int SETTLE_TIME_US = 90;
  // Return-to-top-cell time after a sequence, in us
  localparam int RETURN_TIME_US = 80;
  // Acquisition cycles per 400 ns step, rounded up
  localparam int ACQ_STEP_CYC = (ACQ_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Conversion cycles, rounded up
  localparam int CONV_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Return cycles, rounded up
  localparam int RETURN_CYC = (RETURN_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Counter width for timing
  localparam int TMR_W = 13;
  // Chain delay line stages; each hop forwards the start 3 cycles later
  localparam int CHAIN_DELAY_CYC = 2;
  // Maximum stacked devices
  localparam int MAX_DEVICES = 8;
  // Reset values of the control fields
  localparam logic [1:0] ACQ_SEL_RST = 2'h0;
  localparam logic [1:0] AVG_SEL_RST = 2'h0;
  localparam logic [1:0] CHSET_SEL_RST = 2'h0;
  // Channel set encodings
  localparam logic [1:0] CHSET_ALL = 2'h0;
  localparam logic [1:0] CHSET_ODD_AUX = 2'h1;
  localparam logic [1:0] CHSET_CELLS = 2'h2;
  localparam logic [1:0] CHSET_SELFTEST = 2'h3;
  // Channel indices: 0..5 cell 6 down to cell 1, 6..11 aux 1..6, 12 self-test
  localparam logic [3:0] CH_TOP_CELL = 4'h0;
  localparam logic [3:0] CH_LAST_CELL = 4'h5;
  localparam logic [3:0] CH_FIRST_AUX = 4'h6;
  localparam logic [3:0] CH_LAST_AUX = 4'hb;
  localparam logic [3:0] CH_SELFTEST = 4'hc;
  // Sequencer states
  typedef enum logic [2:0] {
    CST_IDLE = 3'b000,
    CST_ACQ = 3'b001,
    CST_CONV = 3'b010,
    CST_RETURN = 3'b011
  } cst_state_t;
endpackage

// ---- verification/cst_analog_model.sv ----
// Analog core model that hands samples to the sequencer
`timescale 1ns/1ps
module cst_analog_model
  import cst_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // End of each conversion
  input wire logic eoc_pulse,
  // Sample to the sequencer
  output logic [11:0] adc_sample
);
  // New sample after each conversion, so repeats of one channel differ
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adc_sample <= 12'h0f1;
    end else if (eoc_pulse) begin
      adc_sample <= adc_sample + 12'h1a7;
    end
  end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module testbench
  import cst_pkg::*;
;
  // Stimulus
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cfg_write = 1'b0;
  logic [1:0] acq_sel = 2'h0;
  logic [1:0] avg_sel = 2'h0;
  logic [1:0] chs_sel = 2'h0;
  logic pin_start = 1'b0;
  logic cs_start = 1'b0;
  logic chain_in = 1'b0;
  // Observed outputs
  logic chain_out, busy, eoc_pulse, acq_phase, result_valid;
  logic [3:0] mux_channel, result_channel;
  logic [11:0] result_data, adc_sample;
  // Counters
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 clock = ~clock;

  cst_sequencer u_dut (.clock(clock), .rst(rst), .cfg_write(cfg_write), .acquisition_time_select(acq_sel),
    .averaging_count_select(avg_sel), .channel_set_select(chs_sel), .convert_start_pin(pin_start),
    .cs_start(cs_start), .chain_start_in(chain_in), .adc_sample(adc_sample), .chain_start_out(chain_out),
    .busy(busy), .eoc_pulse(eoc_pulse), .mux_channel(mux_channel), .acq_phase(acq_phase),
    .result_valid(result_valid), .result_channel(result_channel), .result_data(result_data));
  cst_analog_model u_model (.clock(clock), .rst(rst), .eoc_pulse(eoc_pulse), .adc_sample(adc_sample));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] expct);
    total_checks++;
    if (seen !== expct) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expct);
    end
  endtask

  // Counts and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      complete_run();
    end
  end

  // Load the fields, then wait the 90 us settle time after an averaging change
  task automatic configure(input logic [1:0] a, input logic [1:0] v, input logic [1:0] c);
    @(posedge clock);
    cfg_write <= 1'b1;
    acq_sel <= a;
    avg_sel <= v;
    chs_sel <= c;
    @(posedge clock);
    cfg_write <= 1'b0;
    repeat (SETTLE_TIME_US * 1000000 / CLK_PERIOD_PS) @(posedge clock);
  endtask

  // One start and the whole sequence that follows
  task automatic run_seq(input logic [1:0] a, input logic [1:0] v, input logic [1:0] c, input int src);
    logic [3:0] chans[$];
    logic [14:0] sum;
    int n, r, last, w, reps;
    reps = 1 << v;
    sum = '0;
    n = 0;
    r = 0;
    last = 0;
    if (c == CHSET_SELFTEST) chans.push_back(CH_SELFTEST);
    else for (int i = 0; i < 12; i++) if (i < 6 || c == CHSET_ALL || (c == CHSET_ODD_AUX && i % 2 == 0))
      chans.push_back(4'(i));
    @(posedge clock);
    case (src)
      0: pin_start <= 1'b1;
      1: cs_start <= 1'b1;
      default: chain_in <= 1'b1;
    endcase
    @(posedge clock);
    {pin_start, cs_start, chain_in} <= 3'h0;
    for (int k = 1; k <= 4; k++) begin
      @(posedge clock);
      #1;
      check(16'(chain_out), 16'(k == 2));
    end
    for (w = 0; w < 20000 && r < chans.size(); w++) begin
      @(posedge clock);
      #1;
      if (eoc_pulse === 1'b1) begin
        if (n > 0) check(16'(w - last), 16'(ACQ_STEP_CYC * (a + 1) + CONV_CYC));
        check(16'({acq_phase, mux_channel}), 16'({1'b0, chans[r]}));
        sum = sum + 15'(adc_sample);
        n++;
        last = w;
      end
      if (result_valid === 1'b1) begin
        check(16'(result_channel), 16'(chans[r]));
        check(16'(n), 16'((r + 1) * reps));
        check(16'(result_data), 16'(sum >> v));
        sum = '0;
        r++;
      end
    end
    check(16'(n), 16'(chans.size() * reps));
    // Start and write while busy: both must be ignored
    repeat (250) @(posedge clock);
    cfg_write <= 1'b1;
    {acq_sel, avg_sel, chs_sel} <= 6'h3f;
    cs_start <= 1'b1;
    @(posedge clock);
    cfg_write <= 1'b0;
    cs_start <= 1'b0;
    repeat (5) begin
      @(posedge clock);
      #1;
      check(16'({busy, chain_out, eoc_pulse}), 16'h0004);
    end
    for (w = 0; w < 4200 && busy !== 1'b0; w++) begin
      @(posedge clock);
      #1;
    end
    check(16'(w), 16'(RETURN_CYC - 255));
    check(16'({busy, acq_phase, mux_channel}), 16'({2'b01, CH_TOP_CELL}));
  endtask

  // Power-up defaults: 400 ns, single conversion, all channels
  task automatic test_defaults();
    check(16'({busy, acq_phase, chain_out, result_valid, mux_channel}), 16'h0040);
    run_seq(2'h0, 2'h0, CHSET_ALL, 0);
    $display("test defaults done");
  endtask

  // Two averages over cells and odd auxiliaries
  task automatic test_average_two();
    configure(2'h1, 2'h1, CHSET_ODD_AUX);
    run_seq(2'h1, 2'h1, CHSET_ODD_AUX, 1);
    $display("test average_two done");
  endtask

  // Ignored write leaves the earlier set in force
  task automatic test_kept_config();
    run_seq(2'h1, 2'h1, CHSET_ODD_AUX, 2);
    $display("test kept_config done");
  endtask

  // Eight averages, cells only, longest acquisition
  task automatic test_cells_eight();
    configure(2'h3, 2'h3, CHSET_CELLS);
    run_seq(2'h3, 2'h3, CHSET_CELLS, 0);
    $display("test cells_eight done");
  endtask

  // Self-test with four averages
  task automatic test_selftest();
    configure(2'h2, 2'h2, CHSET_SELFTEST);
    run_seq(2'h2, 2'h2, CHSET_SELFTEST, 1);
    $display("test selftest done");
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    test_defaults();
    test_average_two();
    test_kept_config();
    test_cells_eight();
    test_selftest();
    complete_run();
  end
endmodule
